//--- hw/tmr_defs.svh
// Purpose: Constants for the 8-bit timer control/status block
// Assumes: One clock domain, plain register port
// Notes: Offsets are register indices on the plain port
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

`define TMR_ADR_CTRL_A 3'h0
`define TMR_ADR_CTRL_B 3'h1
`define TMR_ADR_COUNT 3'h2
`define TMR_ADR_CMP_A 3'h3
`define TMR_ADR_CMP_B 3'h4
`define TMR_ADR_MASK 3'h5
`define TMR_ADR_FLAGS 3'h6

`define TMR_FORCE_A_BIT 7
`define TMR_FORCE_B_BIT 6
`define TMR_WGM2_BIT 3
`define TMR_CS_HI 2
`define TMR_CS_LO 0
`define TMR_COMA_HI 7
`define TMR_COMA_LO 6
`define TMR_COMB_HI 5
`define TMR_COMB_LO 4
`define TMR_WGM_HI 1
`define TMR_WGM_LO 0
`define TMR_CTRL_A_MASK 8'hf3
`define TMR_CTRL_B_MASK 8'h0f
`define TMR_IRQ_MASK 8'h07

`define TMR_FLAG_OVF 0
`define TMR_FLAG_CMPA 1
`define TMR_FLAG_CMPB 2

`define TMR_ZERO8 8'h00
`define TMR_MAX8 8'hff
`define TMR_ONE8 8'h01
`define TMR_PRE_W 10
`define TMR_PRE_ZERO 10'h000
`define TMR_PRE_ONE 10'h001
`define TMR_DIV8_M 10'h007
`define TMR_DIV64_M 10'h03f
`define TMR_DIV256_M 10'h0ff
`define TMR_DIV1024_M 10'h3ff

`endif

//--- hw/tmr_pkg.sv
// Purpose: Types for the 8-bit timer control/status block
// Assumes: Constants live in tmr_defs.svh
// Notes: Mode codes follow the waveform mode field
package tmr_pkg;
   typedef enum logic [2:0] {
      TMR_CS_STOP = 3'b000,
      TMR_CS_DIV1 = 3'b001,
      TMR_CS_DIV8 = 3'b010,
      TMR_CS_DIV64 = 3'b011,
      TMR_CS_DIV256 = 3'b100,
      TMR_CS_DIV1024 = 3'b101,
      TMR_CS_EXT_FALL = 3'b110,
      TMR_CS_EXT_RISE = 3'b111
   } tmr_clk_sel_t;

   typedef enum logic [2:0] {
      TMR_WG_NORMAL = 3'b000,
      TMR_WG_PC_FF = 3'b001,
      TMR_WG_CTC = 3'b010,
      TMR_WG_FAST_FF = 3'b011,
      TMR_WG_RSV4 = 3'b100,
      TMR_WG_PC_OCA = 3'b101,
      TMR_WG_RSV6 = 3'b110,
      TMR_WG_FAST_OCA = 3'b111
   } tmr_wave_mode_t;
endpackage : tmr_pkg

//--- hw/tmr_tick_gen.sv
// Purpose: Timer clock enable from prescaler or external count pin
// Assumes: Count pin is synchronous to i_mclk
// Notes: Pin edge seen in the same cycle the pin changes, against its registered level
`timescale 1ns/1ps
`include "tmr_defs.svh"
module tmr_tick_gen (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Control
   input wire tmr_pkg::tmr_clk_sel_t i_clk_sel,
   input wire logic i_ext_pin,
   // Tick
   output logic o_tick
);
   import tmr_pkg::*;

   logic [`TMR_PRE_W-1:0] pre_r, pre_nxt;
   logic pin_r, pin_nxt;

   always_comb begin
      pre_nxt = pre_r + `TMR_PRE_ONE;
      pin_nxt = i_ext_pin;
      unique case (i_clk_sel)
         TMR_CS_STOP: o_tick = 1'b0;
         TMR_CS_DIV1: o_tick = 1'b1;
         TMR_CS_DIV8: o_tick = (pre_r & `TMR_DIV8_M) == `TMR_DIV8_M;
         TMR_CS_DIV64: o_tick = (pre_r & `TMR_DIV64_M) == `TMR_DIV64_M;
         TMR_CS_DIV256: o_tick = (pre_r & `TMR_DIV256_M) == `TMR_DIV256_M;
         TMR_CS_DIV1024: o_tick = pre_r == `TMR_DIV1024_M;
         TMR_CS_EXT_FALL: o_tick = pin_r & ~i_ext_pin;
         TMR_CS_EXT_RISE: o_tick = ~pin_r & i_ext_pin;
      endcase
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         pre_r <= `TMR_PRE_ZERO;
         pin_r <= 1'b0;
      end else if (i_ce) begin
         pre_r <= pre_nxt;
         pin_r <= pin_nxt;
      end
   end
endmodule : tmr_tick_gen

//--- hw/tmr_core.sv
// Purpose: 8-bit timer with two compare channels and status registers
// Assumes: Plain register port, read data one cycle after the strobe
// Notes: Vector acknowledge inputs clear flags like the CPU vector entry
`timescale 1ns/1ps
`include "tmr_defs.svh"
module tmr_core (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Register port
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Pins and CPU side
   input wire logic i_ext_count_pin,
   input wire logic i_global_irq_en,
   input wire logic i_vec_ack_cmpb,
   input wire logic i_vec_ack_cmpa,
   input wire logic i_vec_ack_ovf,
   output logic o_compare_output_a,
   output logic o_compare_output_b,
   output logic o_irq_cmpb,
   output logic o_irq_cmpa,
   output logic o_irq_ovf
);
   import tmr_pkg::*;

   // ==========================================================
   // Helpers
   function automatic logic apply_mode(input logic [1:0] m,
                                       input logic cur);
      unique case (m)
         2'b00: apply_mode = cur;
         2'b01: apply_mode = ~cur;
         2'b10: apply_mode = 1'b0;
         2'b11: apply_mode = 1'b1;
      endcase
   endfunction : apply_mode

   function automatic logic is_pwm(input tmr_wave_mode_t m);
      is_pwm = !(m == TMR_WG_NORMAL || m == TMR_WG_CTC);
   endfunction : is_pwm

   // ==========================================================
   // Registers
   logic [7:0] ctrl_a_r, ctrl_a_nxt;
   logic [7:0] ctrl_b_r, ctrl_b_nxt;
   logic [7:0] count_r, count_nxt;
   logic [7:0] cmp_a_r, cmp_a_nxt;
   logic [7:0] cmp_b_r, cmp_b_nxt;
   logic [2:0] mask_r, mask_nxt;
   logic [2:0] flags_r, flags_nxt;
   logic dir_down_r, dir_down_nxt;
   logic blk_r, blk_nxt;
   logic oca_r, oca_nxt;
   logic ocb_r, ocb_nxt;
   logic [7:0] rdata_r, rdata_nxt;

   tmr_wave_mode_t wmode;
   tmr_clk_sel_t csel;
   logic tick;
   logic [7:0] top;
   logic wr_count, wr_ctrl_b, wr_flags;
   logic match_a, match_b, at_top, ovf_ev, force_a, force_b;
   logic [1:0] com_a, com_b;

   assign wmode = tmr_wave_mode_t'({ctrl_b_r[`TMR_WGM2_BIT],
                                    ctrl_a_r[`TMR_WGM_HI:`TMR_WGM_LO]});
   assign csel = tmr_clk_sel_t'(ctrl_b_r[`TMR_CS_HI:`TMR_CS_LO]);
   assign com_a = ctrl_a_r[`TMR_COMA_HI:`TMR_COMA_LO];
   assign com_b = ctrl_a_r[`TMR_COMB_HI:`TMR_COMB_LO];

   // ==========================================================
   // Timer clock
   tmr_tick_gen u_tick (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_clk_sel(csel),
      .i_ext_pin(i_ext_count_pin),
      .o_tick(tick)
   );

   // ==========================================================
   // Counter and events
   always_comb begin
      wr_count = i_wr && i_addr == `TMR_ADR_COUNT;
      wr_ctrl_b = i_wr && i_addr == `TMR_ADR_CTRL_B;
      wr_flags = i_wr && i_addr == `TMR_ADR_FLAGS;
      unique case (wmode)
         TMR_WG_CTC, TMR_WG_PC_OCA, TMR_WG_FAST_OCA: top = cmp_a_r;
         default: top = `TMR_MAX8;
      endcase
      at_top = count_r == top;
      // Match only counts on a timer tick not blocked by a write
      match_a = tick && !blk_r && count_r == cmp_a_r;
      match_b = tick && !blk_r && count_r == cmp_b_r;
      ovf_ev = 1'b0;
      count_nxt = count_r;
      dir_down_nxt = dir_down_r;
      blk_nxt = blk_r;
      if (tick) begin
         blk_nxt = 1'b0;
         unique case (wmode)
            TMR_WG_PC_FF, TMR_WG_PC_OCA: begin
               if (!dir_down_r && at_top) begin
                  dir_down_nxt = 1'b1;
                  count_nxt = count_r - `TMR_ONE8;
               end else if (dir_down_r && count_r == `TMR_ZERO8) begin
                  ovf_ev = 1'b1;
                  dir_down_nxt = 1'b0;
                  count_nxt = count_r + `TMR_ONE8;
               end else if (dir_down_r) begin
                  count_nxt = count_r - `TMR_ONE8;
               end else begin
                  count_nxt = count_r + `TMR_ONE8;
               end
            end
            TMR_WG_FAST_OCA: begin
               ovf_ev = at_top;
               count_nxt = at_top ? `TMR_ZERO8 : count_r + `TMR_ONE8;
            end
            TMR_WG_CTC: begin
               ovf_ev = count_r == `TMR_MAX8;
               // Clears on any tick at top, even a write-blocked match; never on a forced one
               count_nxt = at_top ? `TMR_ZERO8 : count_r + `TMR_ONE8;
            end
            default: begin
               ovf_ev = count_r == `TMR_MAX8;
               count_nxt = count_r + `TMR_ONE8;
            end
         endcase
      end
      if (wr_count) begin
         count_nxt = i_wdata;
         blk_nxt = 1'b1;
      end
   end

   // ==========================================================
   // Compare outputs
   always_comb begin
      force_a = wr_ctrl_b && i_wdata[`TMR_FORCE_A_BIT] &&
                !is_pwm(wmode);
      force_b = wr_ctrl_b && i_wdata[`TMR_FORCE_B_BIT] &&
                !is_pwm(wmode);
      oca_nxt = oca_r;
      ocb_nxt = ocb_r;
      if (!is_pwm(wmode)) begin
         if (match_a || force_a) begin
            oca_nxt = apply_mode(com_a, oca_r);
         end
         if (match_b || force_b) begin
            ocb_nxt = apply_mode(com_b, ocb_r);
         end
      end else begin
         if (match_a && com_a[1]) begin
            oca_nxt = com_a[0] ^ dir_down_r;
         end
         if (match_b && com_b[1]) begin
            ocb_nxt = com_b[0] ^ dir_down_r;
         end
         if (tick && at_top && (wmode == TMR_WG_FAST_FF ||
                                wmode == TMR_WG_FAST_OCA)) begin
            if (com_a[1]) begin
               oca_nxt = ~com_a[0];
            end
            if (com_b[1]) begin
               ocb_nxt = ~com_b[0];
            end
         end
      end
   end

   // ==========================================================
   // Register file and flags
   always_comb begin
      ctrl_a_nxt = ctrl_a_r;
      ctrl_b_nxt = ctrl_b_r;
      cmp_a_nxt = cmp_a_r;
      cmp_b_nxt = cmp_b_r;
      mask_nxt = mask_r;
      flags_nxt = flags_r;
      if (i_wr) begin
         unique case (i_addr)
            `TMR_ADR_CTRL_A: ctrl_a_nxt = i_wdata & `TMR_CTRL_A_MASK;
            `TMR_ADR_CTRL_B: ctrl_b_nxt = i_wdata & `TMR_CTRL_B_MASK;
            `TMR_ADR_CMP_A: cmp_a_nxt = i_wdata;
            `TMR_ADR_CMP_B: cmp_b_nxt = i_wdata;
            `TMR_ADR_MASK: mask_nxt = i_wdata[2:0];
            default: ;
         endcase
      end
      if (wr_flags) begin
         flags_nxt = flags_nxt & ~i_wdata[2:0];
      end
      if (i_vec_ack_ovf) begin
         flags_nxt[`TMR_FLAG_OVF] = 1'b0;
      end
      if (i_vec_ack_cmpa) begin
         flags_nxt[`TMR_FLAG_CMPA] = 1'b0;
      end
      if (i_vec_ack_cmpb) begin
         flags_nxt[`TMR_FLAG_CMPB] = 1'b0;
      end
      // Sets last so they win; forced compares never reach here
      if (ovf_ev) begin
         flags_nxt[`TMR_FLAG_OVF] = 1'b1;
      end
      if (match_a) begin
         flags_nxt[`TMR_FLAG_CMPA] = 1'b1;
      end
      if (match_b) begin
         flags_nxt[`TMR_FLAG_CMPB] = 1'b1;
      end
      rdata_nxt = `TMR_ZERO8;
      if (i_rd) begin
         unique case (i_addr)
            `TMR_ADR_CTRL_A: rdata_nxt = ctrl_a_r;
            // Force bits and reserved bits stored as zero
            `TMR_ADR_CTRL_B: rdata_nxt = ctrl_b_r;
            `TMR_ADR_COUNT: rdata_nxt = count_r;
            `TMR_ADR_CMP_A: rdata_nxt = cmp_a_r;
            `TMR_ADR_CMP_B: rdata_nxt = cmp_b_r;
            `TMR_ADR_MASK: rdata_nxt = {5'h00, mask_r};
            `TMR_ADR_FLAGS: rdata_nxt = {5'h00, flags_r};
            default: rdata_nxt = `TMR_ZERO8;
         endcase
      end
   end

   // ==========================================================
   // State registers
   // Counter group
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         count_r <= `TMR_ZERO8;
         dir_down_r <= 1'b0;
         blk_r <= 1'b0;
      end else if (i_ce) begin
         count_r <= count_nxt;
         dir_down_r <= dir_down_nxt;
         blk_r <= blk_nxt;
      end
   end

   // Compare output group
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         oca_r <= 1'b0;
         ocb_r <= 1'b0;
      end else if (i_ce) begin
         oca_r <= oca_nxt;
         ocb_r <= ocb_nxt;
      end
   end

   // Register file group
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ctrl_a_r <= `TMR_ZERO8;
         ctrl_b_r <= `TMR_ZERO8;
         cmp_a_r <= `TMR_ZERO8;
         cmp_b_r <= `TMR_ZERO8;
         mask_r <= 3'h0;
         flags_r <= 3'h0;
         rdata_r <= `TMR_ZERO8;
      end else if (i_ce) begin
         ctrl_a_r <= ctrl_a_nxt;
         ctrl_b_r <= ctrl_b_nxt;
         cmp_a_r <= cmp_a_nxt;
         cmp_b_r <= cmp_b_nxt;
         mask_r <= mask_nxt;
         flags_r <= flags_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign o_rdata = rdata_r;
   assign o_compare_output_a = oca_r;
   assign o_compare_output_b = ocb_r;
   assign o_irq_cmpb = i_global_irq_en & mask_r[`TMR_FLAG_CMPB] &
                       flags_r[`TMR_FLAG_CMPB];
   assign o_irq_cmpa = i_global_irq_en & mask_r[`TMR_FLAG_CMPA] &
                       flags_r[`TMR_FLAG_CMPA];
   assign o_irq_ovf = i_global_irq_en & mask_r[`TMR_FLAG_OVF] &
                      flags_r[`TMR_FLAG_OVF];
endmodule : tmr_core

//--- tb/tmr_core_sva.sv
// Purpose: Port checks for the timer control/status block
// Assumes: One clock; control fields shadowed from port writes
// Notes: Bound to tmr_core from tb_top
`timescale 1ns/1ps
module tmr_core_sva (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Register port
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   // Pins and CPU side
   input wire logic i_global_irq_en,
   input wire logic o_compare_output_a,
   input wire logic o_compare_output_b,
   input wire logic o_irq_cmpb,
   input wire logic o_irq_cmpa,
   input wire logic o_irq_ovf
);
   logic [7:0] cta_r, ctb_r, msk_r;
   logic [2:0] fwgm;
   logic stw, pwm;
   // ==========
   // Shadow copies of written control fields
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cta_r <= 8'h00;
         ctb_r <= 8'h00;
         msk_r <= 8'h00;
      end else if (i_ce && i_wr) begin
         case (i_addr)
            3'h0: cta_r <= i_wdata;
            3'h1: ctb_r <= i_wdata;
            3'h5: msk_r <= i_wdata;
            default: ;
         endcase
      end
   end
   // Control B write while the timer stays stopped
   assign fwgm = {i_wdata[3], cta_r[1:0]};
   assign pwm = fwgm[0] | fwgm[2];
   assign stw = i_wr && i_addr == 3'h1 && ctb_r[2:0] == 3'h0
      && i_wdata[2:0] == 3'h0;
   // ==========
   // Properties
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   sequence s_frc_a;
      stw && !pwm && i_wdata[7] && cta_r[7];
   endsequence
   sequence s_frc_b;
      stw && !pwm && i_wdata[6] && cta_r[5];
   endsequence
   AST_FORCE_A:
   assert property (s_frc_a |=> o_compare_output_a == $past(cta_r[6]))
      else $error("Forced compare A gave wrong output");
   AST_FORCE_B:
   assert property (s_frc_b |=> o_compare_output_b == $past(cta_r[4]))
      else $error("Forced compare B gave wrong output");
   AST_FORCE_PWM:
   assert property (stw && pwm |=>
      $stable({o_compare_output_a, o_compare_output_b}))
      else $error("Force acted in a PWM mode");
   AST_RD_CTRLB:
   assert property (i_rd && i_addr == 3'h1 |=>
      o_rdata == {4'h0, ctb_r[3:0]})
      else $error("Control B read back wrong");
   AST_RD_MASK:
   assert property (i_rd && i_addr == 3'h5 |=>
      o_rdata == {5'h00, msk_r[2:0]})
      else $error("Mask read back wrong");
   AST_RD_FLAGS:
   assert property (i_rd && i_addr == 3'h6 |=> o_rdata[7:3] == 5'h00)
      else $error("Flag reserved bits not zero");
   AST_RD_IDLE:
   assert property (!i_rd || i_addr == 3'h7 |=> o_rdata == 8'h00)
      else $error("Read data not zero outside a read");
   AST_IRQ_GATE:
   assert property (o_irq_cmpb || o_irq_cmpa || o_irq_ovf |->
      i_global_irq_en)
      else $error("Interrupt without global enable");
   AST_IRQ_MASK:
   assert property (({o_irq_cmpb, o_irq_cmpa, o_irq_ovf} & ~msk_r[2:0])
      == 3'h0)
      else $error("Interrupt while masked");
endmodule : tmr_core_sva

//--- tb/tb_top.sv
// Purpose: Self-checking bench for the timer control/status block
// Assumes: Read data stands one cycle after the read strobe
// Notes: Seeded random compare values and pin pulse counts
`timescale 1ns/1ps
`include "tmr_defs.svh"
`define CHK(g, e) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); \
   end \
end
module tb_top;
   import tmr_pkg::*;
   logic i_mclk, i_rst, wr_s, rd_s, pin, gie, oa, ob, ea, eb;
   logic [2:0] adr, ack, irq;
   logic [7:0] wdat, rdat, a, b;
   int k;
   int errors = 0;
   int check_count = 0;
   int dv[6] = '{0, 1, 8, 64, 256, 1024};
   int ns[6] = '{100, 200, 800, 320, 768, 2048};
   logic [1:0] cm[4] = '{2'h3, 2'h1, 2'h1, 2'h2};
   tmr_core uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_ce(1'b1),
      .i_addr(adr), .i_wdata(wdat), .i_wr(wr_s), .i_rd(rd_s),
      .o_rdata(rdat), .i_ext_count_pin(pin), .i_global_irq_en(gie),
      .i_vec_ack_cmpb(ack[2]), .i_vec_ack_cmpa(ack[1]),
      .i_vec_ack_ovf(ack[0]), .o_compare_output_a(oa),
      .o_compare_output_b(ob), .o_irq_cmpb(irq[2]),
      .o_irq_cmpa(irq[1]), .o_irq_ovf(irq[0]));
   // ==========
   // Expectations and bus tasks
   function automatic logic [7:0] exp_cnt(input int n, input int d);
      return (d == 0) ? 8'h00 : 8'(n / d);
   endfunction : exp_cnt
   function automatic logic exp_out(input logic [1:0] c, input logic cur);
      case (c)
         2'h1: return ~cur;
         2'h2: return 1'b0;
         2'h3: return 1'b1;
         default: return cur;
      endcase
   endfunction : exp_out
   task automatic wr(input logic [2:0] ad, input logic [7:0] d);
      @(posedge i_mclk);
      wr_s <= 1'b1;
      adr <= ad;
      wdat <= d;
      @(posedge i_mclk);
      wr_s <= 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [2:0] ad, input logic [7:0] e);
      @(posedge i_mclk);
      rd_s <= 1'b1;
      adr <= ad;
      @(posedge i_mclk);
      rd_s <= 1'b0;
      #1;
      `CHK(rdat, e)
   endtask : rd_chk
   // Timer runs for exactly n edges, then stops
   task automatic run(input tmr_clk_sel_t cs, input int n);
      wr(`TMR_ADR_CTRL_B, {5'h00, cs});
      repeat (n - 2) @(posedge i_mclk);
      wr(`TMR_ADR_CTRL_B, 8'h00);
   endtask : run
   task automatic ack_pulse(input logic [2:0] m);
      @(posedge i_mclk);
      ack <= m;
      @(posedge i_mclk);
      ack <= 3'b000;
   endtask : ack_pulse
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : complete_run
   // ==========
   // Clock, watchdog and tests
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   initial begin
      repeat (20000) @(posedge i_mclk);
      errors++;
      complete_run();
   end
   initial begin
      {i_rst, wr_s, rd_s, pin, gie, adr, ack, wdat} = {5'h10, 14'h0};
      void'($urandom(98));
      repeat (16) @(posedge i_mclk);
      i_rst <= 1'b0;
      rd_chk(`TMR_ADR_MASK, 8'h00);
      rd_chk(`TMR_ADR_FLAGS, 8'h00);
      wr(`TMR_ADR_CTRL_B, 8'h38);
      rd_chk(`TMR_ADR_CTRL_B, 8'h08);
      wr(`TMR_ADR_MASK, 8'hff);
      rd_chk(`TMR_ADR_MASK, 8'h07);
      wr(`TMR_ADR_MASK, 8'h00);
      wr(3'h7, 8'hff);
      rd_chk(3'h7, 8'h00);
      a = 8'($urandom);
      wr(`TMR_ADR_COUNT, a);
      rd_chk(`TMR_ADR_COUNT, a);
      wr(`TMR_ADR_CMP_A, ~a);
      rd_chk(`TMR_ADR_CMP_A, ~a);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         wr(`TMR_ADR_COUNT, 8'h00);
         run(tmr_clk_sel_t'(i), ns[i]);
         rd_chk(`TMR_ADR_COUNT, exp_cnt(ns[i], dv[i]));
      end
      for (int p = 6; p < 8; p++) begin
         k = $urandom_range(10, 1);
         wr(`TMR_ADR_COUNT, 8'h00);
         wr(`TMR_ADR_CTRL_B, 8'(p));
         repeat (k) begin
            @(posedge i_mclk) pin <= 1'b1;
            @(posedge i_mclk) pin <= 1'b0;
         end
         repeat (3) @(posedge i_mclk);
         wr(`TMR_ADR_CTRL_B, 8'h00);
         rd_chk(`TMR_ADR_COUNT, 8'(k));
      end
      $display("test clock select done");
      wr(`TMR_ADR_FLAGS, 8'h07);
      a = 8'($urandom_range(8'h7f, 8'h20));
      b = a + 8'($urandom_range(8'h40, 8'h02));
      wr(`TMR_ADR_CMP_A, a);
      wr(`TMR_ADR_CMP_B, b);
      wr(`TMR_ADR_COUNT, 8'h00);
      run(TMR_CS_DIV1, a);
      rd_chk(`TMR_ADR_FLAGS, 8'h00);
      run(TMR_CS_DIV1, b - a);
      rd_chk(`TMR_ADR_FLAGS, 8'h02);
      run(TMR_CS_DIV1, 256 - b);
      rd_chk(`TMR_ADR_FLAGS, 8'h07);
      wr(`TMR_ADR_FLAGS, 8'h07);
      wr(`TMR_ADR_COUNT, a);
      run(TMR_CS_DIV1, 2);
      wr(`TMR_ADR_COUNT, b);
      run(TMR_CS_DIV1, 2);
      rd_chk(`TMR_ADR_FLAGS, 8'h00);
      $display("test compare done");
      run(TMR_CS_DIV1, 256);
      wr(`TMR_ADR_MASK, 8'h07);
      #1;
      `CHK(irq, 3'b000)
      @(posedge i_mclk) gie <= 1'b1;
      #1;
      `CHK(irq, 3'b111)
      wr(`TMR_ADR_MASK, 8'h05);
      #1;
      `CHK(irq, 3'b101)
      ack_pulse(3'b001);
      rd_chk(`TMR_ADR_FLAGS, 8'h06);
      wr(`TMR_ADR_FLAGS, 8'h00);
      rd_chk(`TMR_ADR_FLAGS, 8'h06);
      wr(`TMR_ADR_FLAGS, 8'h04);
      rd_chk(`TMR_ADR_FLAGS, 8'h02);
      ack_pulse(3'b110);
      rd_chk(`TMR_ADR_FLAGS, 8'h00);
      `CHK(irq, 3'b000)
      $display("test interrupts done");
      @(posedge i_mclk) gie <= 1'b0;
      wr(`TMR_ADR_COUNT, 8'h5a);
      wr(`TMR_ADR_CMP_A, 8'h5a);
      ea = 1'b0;
      eb = 1'b0;
      for (int m = 0; m < 4; m += 2) begin
         for (int i = 0; i < 4; i++) begin
            wr(`TMR_ADR_CTRL_A, {cm[i], cm[i], 2'h0, 2'(m)});
            ea = exp_out(cm[i], ea);
            eb = exp_out(cm[i], eb);
            wr(`TMR_ADR_CTRL_B, 8'hc0);
            #1;
            `CHK({oa, ob}, {ea, eb})
         end
      end
      rd_chk(`TMR_ADR_FLAGS, 8'h00);
      rd_chk(`TMR_ADR_COUNT, 8'h5a);
      rd_chk(`TMR_ADR_CTRL_B, 8'h00);
      wr(`TMR_ADR_CTRL_A, 8'hf3);
      rd_chk(`TMR_ADR_CTRL_A, 8'hf3);
      wr(`TMR_ADR_CTRL_B, 8'hc0);
      wr(`TMR_ADR_CTRL_B, 8'hc8);
      #1;
      `CHK({oa, ob}, 2'b00)
      wr(`TMR_ADR_CTRL_B, 8'h08);
      #1;
      `CHK({oa, ob}, 2'b00)
      // Overflow tick and write-one clear land on the same edge
      wr(`TMR_ADR_FLAGS, 8'h07);
      wr(`TMR_ADR_COUNT, 8'hff);
      wr(`TMR_ADR_CTRL_B, 8'h07);
      @(posedge i_mclk);
      pin <= 1'b1;
      wr_s <= 1'b1;
      adr <= `TMR_ADR_FLAGS;
      wdat <= 8'h01;
      @(posedge i_mclk);
      pin <= 1'b0;
      wr_s <= 1'b0;
      wr(`TMR_ADR_CTRL_B, 8'h00);
      rd_chk(`TMR_ADR_FLAGS, 8'h01);
      $display("test force done");
      complete_run();
   end
endmodule : tb_top
bind tmr_core tmr_core_sva sva_i (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_global_irq_en(i_global_irq_en),
   .o_compare_output_a(o_compare_output_a),
   .o_compare_output_b(o_compare_output_b), .o_irq_cmpb(o_irq_cmpb),
   .o_irq_cmpa(o_irq_cmpa), .o_irq_ovf(o_irq_ovf));
